/* sbr_params.svh */
`ifndef SBR_PARAMS_SVH
`define SBR_PARAMS_SVH
// reset values of the two masks
`define SBR_SRE_RESET 8'hFF
`define SBR_ESE_RESET 8'hFF
// status byte field positions
`define SBR_BIT_BUSY 0
`define SBR_BIT_MAV 4
`define SBR_BIT_ERR 5
`define SBR_BIT_RQS 6
`define SBR_BIT_ZERO 7
// fixed pattern: b3..b1 one, b7 zero
`define SBR_FIXED_ONES 8'h0E
`define SBR_FIXED_MASK 8'h8E
// event register bit positions
`define SBR_EV_RD 7
`define SBR_EV_WR 6
`define SBR_EV_SYS 5
`define SBR_EV_USR 4
`define SBR_EV_USED 8'hF0
// self-test result codes
`define SBR_TST_OK 8'h00
`define SBR_TST_FAULT 8'h01
// cycles of the self-test run
`define SBR_TST_CYCLES 8'h10
`endif

/* sbr_pkg.sv */
package sbr_pkg;
    // command codes decoded upstream, with or without the asterisk
    typedef enum logic [3:0] {
        SBR_CMD_NONE = 4'h0,
        SBR_CMD_SRE_SET = 4'h1,
        SBR_CMD_SRE_Q = 4'h2,
        SBR_CMD_STB_Q = 4'h3,
        SBR_CMD_ESR_Q = 4'h4,
        SBR_CMD_ESE_SET = 4'h5,
        SBR_CMD_ESE_Q = 4'h6,
        SBR_CMD_IDN_Q = 4'h7,
        SBR_CMD_RST = 4'h8,
        SBR_CMD_TST_Q = 4'h9,
        SBR_CMD_CLS = 4'hA
    } sbr_cmd_e;
    typedef enum logic [2:0] {
        SBR_ST_IDLE = 3'b001,
        SBR_ST_TEST = 3'b010,
        SBR_ST_DONE = 3'b100
    } sbr_state_e;
    typedef struct packed {
        logic valid;
        sbr_cmd_e cmd;
        logic [7:0] value;
    } sbr_req_s;
    typedef struct packed {
        logic valid;
        logic [7:0] value;
    } sbr_rsp_s;
    typedef struct packed {
        logic rd_incomplete;
        logic wr_incomplete;
        logic sys_error;
        logic user_error;
    } sbr_event_s;
endpackage

/* sbr_status.sv */
`timescale 1ns/100ps
`include "sbr_params.svh"
// Notes on behaviour
// - mask assignment stores value 0..255 as status enable mask
// - status query returns status byte anded with enable mask
// - serial poll returns the status byte unmasked
// - bit 0 is one while any axis moves
// - bit 6 set internally when output ready; never masked
// - bit 4 shows output buffer holds characters
// - bit 5 shows a detected error condition
// - with mask 1 query gives 0x00 idle, 0x01 busy, plus bit 6
// - enable mask query returns mask; resets to 0xFF
// - event query returns read, write, system, user error bits; low zero
// - event enable mask gates which events reach the summary
// - event mask assignment stored, resets to 0xFF
// - event mask query returns stored event mask
// - identity query returns product code xor firmware code
// - reset command returns all state except the last poll byte and poll strobe, masks included, to defaults
// - self-test query returns fault code or normal result code
// - commands accepted with or without leading asterisk
// - clear command empties the event register and clears status bit 5, keeping only events that arrive in the same cycle
module sbr_status
    import sbr_pkg::*;
#(
    parameter int AXES = 3,
    parameter logic [7:0] PRODUCT_CODE = 8'h5A, // arbitrary value
    parameter logic [7:0] FIRMWARE_REV = 8'h01 // arbitrary value
) (
    input wire logic core_clk, // 40 MHz clock
    input wire logic rst_n, // synchronous reset, active low
    input wire sbr_req_s req, // decoded command, one-cycle valid
    output sbr_rsp_s rsp, // query answer, one-cycle valid
    input wire logic poll, // serial poll strobe
    output logic [7:0] poll_byte, // unmasked status byte
    output logic poll_valid, // poll answer strobe
    input wire logic [AXES-1:0] axis_moving, // per-axis motion levels
    input wire logic out_pending, // output buffer holds chars
    input wire logic out_ready, // response data ready for host
    input wire sbr_event_s event_in, // one-cycle event pulses
    input wire logic selftest_fault, // internal fault level
    output logic cold_reset // pulse to reset rest of device
);
    logic [7:0] sre_mask;
    logic [7:0] ese_mask;
    logic [7:0] event_status_flags;
    logic [7:0] stb;
    logic err_flag;
    logic busy;
    logic [7:0] tst_cnt;
    logic tst_fault;
    sbr_state_e state;
    logic do_rst;
    logic next_err_flag;

    // cold reset command acts like the reset pin for this block, except poll_byte and poll_valid
    // cold reset
    assign do_rst = req.valid && (req.cmd == SBR_CMD_RST);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cold_reset <= 1'b0;
        end else begin
            cold_reset <= do_rst;
        end
    end

    assign busy = |axis_moving;

    // enable masks; asterisk stripping is done by the parser upstream
    // either spelling, same code
    always_ff @(posedge core_clk) begin
        if (!rst_n || do_rst) begin
            sre_mask <= `SBR_SRE_RESET;
        end else if (req.valid && req.cmd == SBR_CMD_SRE_SET) begin
            sre_mask <= req.value;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n || do_rst) begin
            ese_mask <= `SBR_ESE_RESET;
        end else if (req.valid && req.cmd == SBR_CMD_ESE_SET) begin
            ese_mask <= req.value;
        end
    end

    // event register: sticky, cleared by its query or by clear command;
    // a new event in the clearing cycle still lands
    // event bits
    always_ff @(posedge core_clk) begin
        if (!rst_n || do_rst) begin
            event_status_flags <= 8'h00;
        end else begin
            if (req.valid && (req.cmd == SBR_CMD_ESR_Q ||
                              req.cmd == SBR_CMD_CLS)) begin
                event_status_flags <= {event_in, 4'h0};
            end else begin
                event_status_flags <= event_status_flags | {event_in, 4'h0};
            end
        end
    end

    // error summary: enabled events, cleared by clear command unless an enabled event arrives in that cycle
    // event gating
    always_comb begin
        next_err_flag = err_flag | (|(event_status_flags & ese_mask & `SBR_EV_USED));
        if (req.valid && req.cmd == SBR_CMD_CLS) begin
            next_err_flag = |({event_in, 4'h0} & ese_mask);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n || do_rst) begin
            err_flag <= 1'b0;
        end else begin
            err_flag <= next_err_flag;
        end
    end

    // status byte assembly; mav tracks the buffer level directly so it
    // drops the cycle the last character leaves
    // fixed bits
    always_comb begin
        stb = `SBR_FIXED_ONES;
        stb[`SBR_BIT_BUSY] = busy;
        stb[`SBR_BIT_MAV] = out_pending;
        stb[`SBR_BIT_ERR] = err_flag;
        stb[`SBR_BIT_RQS] = out_ready;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            poll_byte <= 8'h00;
            poll_valid <= 1'b0;
        end else begin
            poll_valid <= poll;
            if (poll) begin
                poll_byte <= stb;
            end
        end
    end

    // self-test: short fixed run, fault sampled along the way
    // self-test run
    always_ff @(posedge core_clk) begin
        if (!rst_n || do_rst) begin
            state <= SBR_ST_IDLE;
            tst_cnt <= 8'h00;
            tst_fault <= 1'b0;
        end else begin
            case (state)
                SBR_ST_IDLE: begin
                    if (req.valid && req.cmd == SBR_CMD_TST_Q) begin
                        state <= SBR_ST_TEST;
                        tst_cnt <= `SBR_TST_CYCLES;
                        tst_fault <= 1'b0;
                    end
                end
                SBR_ST_TEST: begin
                    tst_fault <= tst_fault | selftest_fault;
                    tst_cnt <= tst_cnt - 8'h01;
                    if (tst_cnt == 8'h01) begin
                        state <= SBR_ST_DONE;
                    end
                end
                SBR_ST_DONE: begin
                    state <= SBR_ST_IDLE;
                end
                default: begin
                    state <= SBR_ST_IDLE;
                end
            endcase
        end
    end

    // query answers, one cycle after the request; self-test answer one cycle after the DONE state
    always_ff @(posedge core_clk) begin
        if (!rst_n || do_rst) begin
            rsp <= '0;
        end else begin
            rsp.valid <= 1'b0;
            if (state == SBR_ST_DONE) begin
                rsp.valid <= 1'b1;
                rsp.value <= tst_fault ? `SBR_TST_FAULT : `SBR_TST_OK;
            end else if (req.valid) begin
                case (req.cmd)
                    SBR_CMD_STB_Q: begin
                        rsp.valid <= 1'b1;
                        rsp.value <= (stb & sre_mask) |
                                     (stb & 8'h40);
                    end
                    SBR_CMD_SRE_Q: begin
                        rsp.valid <= 1'b1;
                        rsp.value <= sre_mask;
                    end
                    SBR_CMD_ESR_Q: begin
                        rsp.valid <= 1'b1;
                        rsp.value <= event_status_flags & `SBR_EV_USED;
                    end
                    SBR_CMD_ESE_Q: begin
                        rsp.valid <= 1'b1;
                        rsp.value <= ese_mask;
                    end
                    SBR_CMD_IDN_Q: begin
                        rsp.valid <= 1'b1;
                        rsp.value <= PRODUCT_CODE ^ FIRMWARE_REV;
                    end
                    default: begin
                        rsp.valid <= 1'b0;
                    end
                endcase
            end
        end
    end

    AST_FIXED_BITS:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        poll |=> ((poll_byte & `SBR_FIXED_MASK) == `SBR_FIXED_ONES))
        else $error("fixed status bits wrong");

    AST_POLL_BUSY:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        poll |=> (poll_byte[0] == $past(busy)) && poll_valid)
        else $error("poll busy bit wrong");

    AST_POLL_MAV:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        poll |=> poll_byte[`SBR_BIT_MAV] == $past(out_pending))
        else $error("poll buffer bit wrong");

    AST_POLL_ERR:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        poll |=> poll_byte[`SBR_BIT_ERR] == $past(err_flag))
        else $error("poll error bit wrong");

    // mask reset; the first edges of the run are held off
    AST_SRE_DEFAULT:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        $past(!rst_n) |-> sre_mask == 8'hFF)
        else $error("enable mask not default");

    AST_ESE_DEFAULT:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        do_rst |=> ese_mask == 8'hFF)
        else $error("event mask not default after reset command");

    AST_COLD_RESET:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        do_rst |=> cold_reset && sre_mask == `SBR_SRE_RESET &&
        event_status_flags == 8'h00 && !err_flag)
        else $error("cold reset incomplete");

    AST_SRE_STORE:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        (req.valid && req.cmd == SBR_CMD_SRE_SET) |=>
        sre_mask == $past(req.value))
        else $error("enable mask not stored");

    AST_STB_MASK:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        (req.valid && req.cmd == SBR_CMD_STB_Q && state != SBR_ST_DONE)
        |=> rsp.valid && rsp.value[0] == ($past(busy) & $past(sre_mask[0])))
        else $error("status query masking wrong");

    AST_RQS_UNMASKED:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        (req.valid && req.cmd == SBR_CMD_STB_Q && state != SBR_ST_DONE)
        |=> rsp.value[`SBR_BIT_RQS] == $past(out_ready))
        else $error("request bit masked in status query");

    AST_ESR_LOW:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        event_status_flags[3:0] == 4'h0)
        else $error("event low bits set");

    AST_ERR_SET:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        ((|(event_status_flags & ese_mask & `SBR_EV_USED)) && !do_rst &&
         !(req.valid && req.cmd == SBR_CMD_CLS)) |=> err_flag)
        else $error("enabled event did not raise error");

    AST_CLS_CLEAR:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        (req.valid && req.cmd == SBR_CMD_CLS && event_in == '0) |=>
        !err_flag && event_status_flags == 8'h00)
        else $error("clear left error state");

    AST_ESE_READ:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        (req.valid && req.cmd == SBR_CMD_ESE_Q && state != SBR_ST_DONE)
        |=> rsp.valid && rsp.value == $past(ese_mask))
        else $error("event mask readback wrong");

    AST_TST_DONE:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == SBR_ST_IDLE && req.valid && req.cmd == SBR_CMD_TST_Q)
        |=> (state == SBR_ST_TEST) ##16 (state == SBR_ST_DONE) ##1 rsp.valid)
        else $error("self-test timing wrong");
endmodule

/* sbr_host.sv */
`timescale 1ns/100ps
module sbr_host
    import sbr_pkg::*;
(
    input wire logic core_clk, // device clock
    output sbr_req_s req, // command to device
    input wire sbr_rsp_s rsp, // query answer
    output logic poll, // serial poll strobe
    input wire logic [7:0] poll_byte, // polled status byte
    input wire logic poll_valid, // poll answer strobe
    output logic timed_out // some wait ran out
);
    // idle bus at time zero
    initial begin
        req = '0;
        poll = 1'b0;
        timed_out = 1'b0;
    end

    // one command held for one edge; queries wait a bounded time
    task automatic send(input sbr_cmd_e c, input logic [7:0] v,
                        input bit w, output logic [7:0] ans);
        ans = 8'h00;
        @(posedge core_clk);
        #1;
        req = '{valid: 1'b1, cmd: c, value: v};
        @(posedge core_clk);
        #1;
        req.valid = 1'b0;
        req.value = ~v; // stale data must not look valid
        // the answer stands only one cycle, so look before the next edge
        for (int n = 0; w && n < 30; n++) begin
            if (rsp.valid === 1'b1) begin
                ans = rsp.value;
                return;
            end
            @(posedge core_clk);
            #1;
        end
        if (w) timed_out = 1'b1;
    endtask

    // serial poll; answer stands one cycle after the strobe
    task automatic do_poll(output logic [7:0] b);
        b = 8'h00;
        @(posedge core_clk);
        #1;
        poll = 1'b1;
        @(posedge core_clk);
        #1;
        poll = 1'b0;
        // poll_valid is a one-cycle pulse from the taking edge
        for (int n = 0; n < 4; n++) begin
            if (poll_valid === 1'b1) begin
                b = poll_byte;
                return;
            end
            @(posedge core_clk);
            #1;
        end
        timed_out = 1'b1;
    endtask

    task automatic wait_idle();
        logic [7:0] b;
        for (int n = 0; n < 200; n++) begin
            do_poll(b);
            if ((b & 8'h01) === 8'h00) return;
        end
        timed_out = 1'b1;
    endtask
endmodule

/* sbr_status_tb.sv */
`timescale 1ns/100ps
module sbr_status_tb import sbr_pkg::*;;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] axis_moving = '0;
    logic out_pending = 1'b0;
    logic out_ready = 1'b0;
    logic selftest_fault = 1'b0;
    sbr_event_s event_in = '0;
    sbr_req_s req;
    sbr_rsp_s rsp;
    logic poll, poll_valid, cold_reset, timed_out;
    logic [7:0] poll_byte, a;
    int mismatches = 0;
    int cmp_count = 0;
    // rows: mask, moving, pending, ready, query answer, poll answer
    logic [7:0] tbl [6][6] = '{
        '{8'hFF, 8'h00, 8'h00, 8'h00, 8'h0E, 8'h0E},
        '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0E},
        '{8'h01, 8'h01, 8'h00, 8'h00, 8'h01, 8'h0F},
        '{8'h01, 8'h00, 8'h00, 8'h01, 8'h40, 8'h4E},
        '{8'h10, 8'h00, 8'h01, 8'h00, 8'h10, 8'h1E},
        '{8'h00, 8'h04, 8'h01, 8'h01, 8'h40, 8'h5F}};

    // free-running 40 MHz clock
    always #12.5 core_clk = ~core_clk;

    sbr_status #(.AXES(3), .PRODUCT_CODE(8'hA5), .FIRMWARE_REV(8'h3C)) DUT (
        .core_clk, .rst_n, .req, .rsp, .poll, .poll_byte, .poll_valid,
        .axis_moving, .out_pending, .out_ready, .event_in,
        .selftest_fault, .cold_reset);

    sbr_host host (.core_clk, .req, .rsp, .poll, .poll_byte, .poll_valid,
        .timed_out);

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic q(input sbr_cmd_e c, input logic [7:0] v, exp);
        host.send(c, v, 1'b1, a);
        check(a, exp);
    endtask

    task automatic set(input sbr_cmd_e c, input logic [7:0] v);
        host.send(c, v, 1'b0, a);
    endtask

    task automatic sp(input logic [7:0] exp);
        host.do_poll(a);
        check(a, exp);
    endtask

    // event pulses last exactly one cycle
    task automatic pulse(input logic [3:0] e);
        @(posedge core_clk);
        #1;
        event_in = e;
        @(posedge core_clk);
        #1;
        event_in = '0;
    endtask

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // a host wait that ran out ends the run
    always @(posedge timed_out) begin
        mismatches++;
        report_and_stop();
    end

    // main sequence
    initial begin
        repeat (3) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        q(SBR_CMD_SRE_Q, 8'h00, 8'hFF);
        q(SBR_CMD_ESE_Q, 8'h00, 8'hFF);
        q(SBR_CMD_ESR_Q, 8'h00, 8'h00);
        $display("reset test done");
        for (int i = 0; i < 6; i++) begin
            set(SBR_CMD_SRE_SET, tbl[i][0]);
            q(SBR_CMD_SRE_Q, 8'h00, tbl[i][0]);
            axis_moving = tbl[i][1][2:0];
            out_pending = tbl[i][2][0];
            out_ready = tbl[i][3][0];
            q(SBR_CMD_STB_Q, 8'h00, tbl[i][4]);
            sp(tbl[i][5]);
        end
        $display("table test done");
        axis_moving = '0;
        out_pending = 1'b0;
        out_ready = 1'b0;
        // each event bit reaches its place and the error flag
        for (int k = 0; k < 4; k++) begin
            set(SBR_CMD_ESE_SET, 8'h10 << k);
            q(SBR_CMD_ESE_Q, 8'h00, 8'h10 << k);
            pulse(4'b0001 << k);
            sp(8'h2E);
            q(SBR_CMD_ESR_Q, 8'h00, 8'h10 << k);
            set(SBR_CMD_CLS, 8'h00);
            sp(8'h0E);
        end
        set(SBR_CMD_ESE_SET, 8'h00);
        pulse(4'b1111);
        sp(8'h0E);
        q(SBR_CMD_ESR_Q, 8'h00, 8'hF0);
        $display("event test done");
        q(SBR_CMD_IDN_Q, 8'h00, 8'hA5 ^ 8'h3C);
        q(SBR_CMD_TST_Q, 8'h00, 8'h00);
        selftest_fault = 1'b1;
        q(SBR_CMD_TST_Q, 8'h00, 8'h01);
        selftest_fault = 1'b0;
        $display("ident and self-test done");
        // masks moved off default first, so the reset has work to do
        set(SBR_CMD_SRE_SET, 8'h12);
        set(SBR_CMD_ESE_SET, 8'h34);
        q(SBR_CMD_SRE_Q, 8'h00, 8'h12);
        set(SBR_CMD_RST, 8'h00);
        check({7'h00, cold_reset}, 8'h01);
        @(posedge core_clk);
        #1;
        check({7'h00, cold_reset}, 8'h00);
        q(SBR_CMD_SRE_Q, 8'h00, 8'hFF);
        q(SBR_CMD_ESE_Q, 8'h00, 8'hFF);
        $display("cold reset test done");
        // motion ends while the host keeps polling
        axis_moving = 3'b010;
        fork
            begin
                repeat (40) @(posedge core_clk);
                #1;
                axis_moving = '0;
            end
            host.wait_idle();
        join
        sp(8'h0E);
        out_pending = 1'b1;
        sp(8'h1E);
        out_pending = 1'b0;
        sp(8'h0E);
        $display("busy and output test done");
        // reset pin in mid-run: state built up first, then dropped
        set(SBR_CMD_SRE_SET, 8'h5A);
        set(SBR_CMD_ESE_SET, 8'h2F);
        q(SBR_CMD_SRE_Q, 8'h00, 8'h5A);
        q(SBR_CMD_ESE_Q, 8'h00, 8'h2F);
        pulse(4'b0010);
        sp(8'h2E);
        rst_n = 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        check(poll_byte, 8'h00);
        sp(8'h0E);
        q(SBR_CMD_SRE_Q, 8'h00, 8'hFF);
        q(SBR_CMD_ESE_Q, 8'h00, 8'hFF);
        q(SBR_CMD_ESR_Q, 8'h00, 8'h00);
        $display("pin reset test done");
        report_and_stop();
    end
endmodule
